/* src/ibs_framer.sv */
/*
  in-band padding framer: builds type A and optional type B blocks as a bit stream, apb registers.
  assumes frame_start and first_of_interleave come from same-clock framing logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.svh"
module ibs_framer
    import ibs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_start,
    input wire logic first_of_interleave,
    output logic bit_out,
    output logic bit_valid,
    input wire logic bit_ready,
    output logic bit_last,
    output logic block_done,
    output logic busy,
    output logic short_delay_required,
    output logic [`IBS_ISSY_MANT_W-1:0] short_delay_mantissa,
    output logic [`IBS_ISSY_EXP_W-1:0] short_delay_exponent
);
    // software registers
    logic [31:0] ctrl;
    logic [7:0] change_count;
    logic [9:0] block_count;
    logic [11:0] rf_index_pack;
    logic [21:0] interval_tab [`IBS_MAX_FRAMES];
    logic [21:0] start_tab [`IBS_MAX_FRAMES];
    logic [21:0] type2_tab [`IBS_MAX_FRAMES];
    logic [30:0] output_delay_count;
    logic [21:0] first_input_clock_ref;
    logic [1:0] buffer_size_scale;
    logic [9:0] buffer_size_value;
    logic [26:0] stream_rate;

    // sequencer state
    ibs_state_type state;
    ibs_state_type next_state;
    logic [2:0] fidx;
    logic [2:0] next_fidx;
    logic [1:0] frame;
    logic [1:0] next_frame;
    logic [1:0] last_frame;
    logic send_b;
    logic last_had_b;
    logic [15:0] blocks_sent;

    // shifter handshake
    logic accept;
    logic shifter_empty;
    logic shifter_final;
    logic [31:0] field_value;
    logic [5:0] field_width;

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire [1:0] tab_sel = paddr[3:2];
    wire hit_ctrl = paddr == `IBS_OFF_CTRL;
    wire hit_status = paddr == `IBS_OFF_STATUS;
    wire hit_change = paddr == `IBS_OFF_CHANGE;
    wire hit_blocks = paddr == `IBS_OFF_BLOCKS;
    wire hit_rf = paddr == `IBS_OFF_RF_IDX;
    wire hit_interval = paddr[7:4] == `IBS_OFF_INTERVAL >> 4 && paddr[1:0] == 2'h0;
    wire hit_start = paddr[7:4] == `IBS_OFF_START >> 4 && paddr[1:0] == 2'h0;
    wire hit_type2 = paddr[7:4] == `IBS_OFF_TYPE2 >> 4 && paddr[1:0] == 2'h0;
    wire hit_delay = paddr == `IBS_OFF_DELAY;
    wire hit_icr = paddr == `IBS_OFF_ICR;
    wire hit_buf = paddr == `IBS_OFF_BUF;
    wire hit_rate = paddr == `IBS_OFF_RATE;
    wire hit_issy = paddr == `IBS_OFF_ISSY;
    wire mapped = hit_ctrl | hit_status | hit_change | hit_blocks | hit_rf | hit_interval | hit_start
        | hit_type2 | hit_delay | hit_icr | hit_buf | hit_rate | hit_issy;

    // control fields
    wire enable = ctrl[`IBS_CTRL_ENABLE];
    wire type_b_enable = ctrl[`IBS_CTRL_TYPE_B];
    wire tfs_enable = ctrl[`IBS_CTRL_TFS];
    wire [2:0] frames_cfg = ctrl[`IBS_CTRL_FRAMES_HI:`IBS_CTRL_FRAMES_LO];
    // zero frames still sends one group; above the table size clamps
    wire [1:0] frames_m1 = (frames_cfg == 3'h0) ? 2'h0 : (frames_cfg > 3'h4) ? 2'h3 : frames_cfg[1:0] - 2'h1;

    wire [2:0] rf_for_frame = rf_index_pack[frame*3 +: 3];
    wire [2:0] rf_sent = tfs_enable ? rf_for_frame : 3'h0;
    wire start_block = (state == ST_IDLE) & enable & frame_start;
    wire active = (state != ST_IDLE) & (state != ST_DRAIN);
    wire load = active & accept;

    wire [31:0] status_word = {blocks_sent, 13'h0000, last_had_b, send_b, busy};
    wire [31:0] issy_word = {16'h0000, 1'b0, short_delay_exponent, short_delay_mantissa};

    function automatic logic [31:0] pad32(input logic [30:0] v);
        return {1'b0, v};
    endfunction

    // read mux
    wire [31:0] read_mux =
        hit_ctrl ? ctrl :
        hit_status ? status_word :
        hit_change ? {24'h000000, change_count} :
        hit_blocks ? {22'h000000, block_count} :
        hit_rf ? {20'h00000, rf_index_pack} :
        hit_interval ? {10'h000, interval_tab[tab_sel]} :
        hit_start ? {10'h000, start_tab[tab_sel]} :
        hit_type2 ? {10'h000, type2_tab[tab_sel]} :
        hit_delay ? pad32(output_delay_count) :
        hit_icr ? {10'h000, first_input_clock_ref} :
        hit_buf ? {14'h0000, buffer_size_value, 6'h00, buffer_size_scale} :
        hit_rate ? {5'h00, stream_rate} :
        hit_issy ? issy_word : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // field table, in transmission order
    always_comb begin
        field_value = 32'h0000_0000;
        field_width = `IBS_W_RES8;
        case (state)
            ST_HEAD: begin
                case (fidx)
                    3'h0: begin
                        field_value = {30'h0, `IBS_KIND_A};
                        field_width = `IBS_W_KIND;
                    end
                    3'h1: begin
                        field_value = {24'h0, change_count};
                        field_width = `IBS_W_CHANGE;
                    end
                    default: begin
                        field_value = 32'h0000_0000;
                        field_width = `IBS_W_RES8;
                    end
                endcase
            end
            ST_LOOP: begin
                case (fidx)
                    3'h0: begin
                        field_value = {10'h0, interval_tab[frame]};
                        field_width = `IBS_W_INTERVAL;
                    end
                    3'h1: begin
                        field_value = {29'h0, rf_sent};
                        field_width = `IBS_W_RF_IDX;
                    end
                    3'h2: begin
                        // zero passes as is: start right after layer-1 data
                        field_value = {10'h0, start_tab[frame]};
                        field_width = `IBS_W_START;
                    end
                    default: begin
                        field_value = 32'h0000_0000;
                        field_width = `IBS_W_RES8;
                    end
                endcase
            end
            ST_MID: begin
                if (fidx == 3'h0) begin
                    field_value = {22'h0, block_count};
                    field_width = `IBS_W_BLOCKS;
                end else begin
                    // no other-pipe entries are built, so the count is always zero
                    field_value = 32'h0000_0000;
                    field_width = `IBS_W_NUM_OTHER;
                end
            end
            ST_TYPE2: begin
                field_value = {10'h0, type2_tab[frame]};
                field_width = `IBS_W_TYPE2;
            end
            ST_TYPEB: begin
                case (fidx)
                    3'h0: begin
                        field_value = {30'h0, `IBS_KIND_B};
                        field_width = `IBS_W_KIND;
                    end
                    3'h1: begin
                        field_value = pad32(output_delay_count);
                        field_width = `IBS_W_DELAY;
                    end
                    3'h2: begin
                        field_value = {10'h0, first_input_clock_ref};
                        field_width = `IBS_W_ICR;
                    end
                    3'h3: begin
                        field_value = {30'h0, buffer_size_scale};
                        field_width = `IBS_W_BUF_SCALE;
                    end
                    3'h4: begin
                        field_value = {22'h0, buffer_size_value};
                        field_width = `IBS_W_BUF_VALUE;
                    end
                    3'h5: begin
                        field_value = {5'h0, stream_rate};
                        field_width = `IBS_W_RATE;
                    end
                    default: begin
                        field_value = 32'h0000_0000;
                        field_width = `IBS_W_RES8;
                    end
                endcase
            end
            default: begin
                field_value = 32'h0000_0000;
                field_width = `IBS_W_RES8;
            end
        endcase
    end

    // sequencing between fields
    always_comb begin
        next_state = state;
        next_fidx = fidx;
        next_frame = frame;
        case (state)
            ST_IDLE: begin
                if (start_block) begin
                    next_state = ST_HEAD;
                    next_fidx = 3'h0;
                    next_frame = 2'h0;
                end
            end
            ST_HEAD: begin
                if (load) begin
                    next_fidx = fidx + 3'h1;
                    if (fidx == 3'h2) begin
                        next_state = ST_LOOP;
                        next_fidx = 3'h0;
                    end
                end
            end
            ST_LOOP: begin
                if (load) begin
                    next_fidx = fidx + 3'h1;
                    if (fidx == 3'h3) begin
                        next_fidx = 3'h0;
                        if (frame == last_frame) begin
                            next_state = ST_MID;
                            next_frame = 2'h0;
                        end else begin
                            next_frame = frame + 2'h1;
                        end
                    end
                end
            end
            ST_MID: begin
                if (load) begin
                    next_fidx = fidx + 3'h1;
                    if (fidx == 3'h1) begin
                        next_state = ST_TYPE2;
                        next_fidx = 3'h0;
                    end
                end
            end
            ST_TYPE2: begin
                if (load) begin
                    next_frame = frame + 2'h1;
                    if (frame == last_frame) begin
                        next_frame = 2'h0;
                        next_state = send_b ? ST_TYPEB : ST_DRAIN;
                    end
                end
            end
            ST_TYPEB: begin
                if (load) begin
                    next_fidx = fidx + 3'h1;
                    if (fidx == 3'h6) begin
                        next_state = ST_DRAIN;
                        next_fidx = 3'h0;
                    end
                end
            end
            ST_DRAIN: begin
                if (shifter_empty) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_fidx = 3'h0;
                next_frame = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= ST_IDLE;
            fidx <= 3'h0;
            frame <= 2'h0;
        end else begin
            state <= next_state;
            fidx <= next_fidx;
            frame <= next_frame;
        end
    end

    // per-block options caught at the start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            send_b <= 1'b0;
            last_frame <= 2'h0;
        end else if (start_block) begin
            send_b <= type_b_enable & first_of_interleave;
            last_frame <= frames_m1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            block_done <= 1'b0;
            last_had_b <= 1'b0;
            blocks_sent <= 16'h0000;
        end else begin
            block_done <= (state == ST_DRAIN) & shifter_empty;
            if ((state == ST_DRAIN) & shifter_empty) begin
                last_had_b <= send_b;
                blocks_sent <= blocks_sent + 16'h0001;
            end
        end
    end

    assign busy = state != ST_IDLE;
    // the header stage keeps the short-form delay in every frame that carries type B
    assign short_delay_required = busy & send_b;
    assign bit_last = (state == ST_DRAIN) & shifter_final;

    // apb register writes; tables are live, so rewrite them only while idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= `IBS_CTRL_RESET;
            change_count <= 8'h00;
            block_count <= 10'h000;
            rf_index_pack <= 12'h000;
            output_delay_count <= 31'h0000_0000;
            first_input_clock_ref <= 22'h000000;
            buffer_size_scale <= 2'h0;
            buffer_size_value <= 10'h000;
            stream_rate <= 27'h0000000;
        end else if (wr) begin
            if (hit_ctrl) ctrl <= {26'h0000000, pwdata[5:0]};
            if (hit_change) change_count <= pwdata[7:0];
            if (hit_blocks) block_count <= pwdata[9:0];
            if (hit_rf) rf_index_pack <= pwdata[11:0];
            if (hit_delay) output_delay_count <= pwdata[30:0];
            if (hit_icr) first_input_clock_ref <= pwdata[21:0];
            if (hit_buf) buffer_size_scale <= pwdata[`IBS_BUF_SCALE_LO +: 2];
            if (hit_buf) buffer_size_value <= pwdata[`IBS_BUF_VALUE_LO +: 10];
            if (hit_rate) stream_rate <= pwdata[26:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `IBS_MAX_FRAMES; i++) begin
                interval_tab[i] <= 22'h000000;
                start_tab[i] <= 22'h000000;
                type2_tab[i] <= 22'h000000;
            end
        end else if (wr) begin
            if (hit_interval) interval_tab[tab_sel] <= pwdata[21:0];
            if (hit_start) start_tab[tab_sel] <= pwdata[21:0];
            if (hit_type2) type2_tab[tab_sel] <= pwdata[21:0];
        end
    end

    // read data is captured in the setup cycle so the access cycle answers at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : read_mux;
        end
    end

    ibs_field_shifter u_shifter (
        .clk(clk),
        .reset(reset),
        .load(load),
        .load_value(field_value),
        .load_width(field_width),
        .accept(accept),
        .empty(shifter_empty),
        .final_bit(shifter_final),
        .bit_out(bit_out),
        .bit_valid(bit_valid),
        .bit_ready(bit_ready)
    );

    ibs_delay_encoder u_delay (
        .clk(clk),
        .reset(reset),
        .delay_count(output_delay_count),
        .mantissa(short_delay_mantissa),
        .exponent(short_delay_exponent)
    );
endmodule
`default_nettype wire

/* src/ibs_defines.svh */
/*
  offsets, field positions, field widths, reset values and codes for the in-band padding framer.
  assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef IBS_DEFINES_SVH
`define IBS_DEFINES_SVH

// register byte offsets on the apb side
`define IBS_OFF_CTRL 8'h00
`define IBS_OFF_STATUS 8'h04
`define IBS_OFF_CHANGE 8'h08
`define IBS_OFF_BLOCKS 8'h0c
`define IBS_OFF_RF_IDX 8'h10
`define IBS_OFF_INTERVAL 8'h20
`define IBS_OFF_START 8'h30
`define IBS_OFF_TYPE2 8'h40
`define IBS_OFF_DELAY 8'h50
`define IBS_OFF_ICR 8'h54
`define IBS_OFF_BUF 8'h58
`define IBS_OFF_RATE 8'h5c
`define IBS_OFF_ISSY 8'h60

// control bit positions
`define IBS_CTRL_ENABLE 0
`define IBS_CTRL_TYPE_B 1
`define IBS_CTRL_FRAMES_LO 2
`define IBS_CTRL_FRAMES_HI 4
`define IBS_CTRL_TFS 5
`define IBS_CTRL_RESET 32'h0000_0006

// per-frame table depth and buffer-size field positions
`define IBS_MAX_FRAMES 4
`define IBS_BUF_SCALE_LO 0
`define IBS_BUF_VALUE_LO 8

// padding-kind codes
`define IBS_KIND_A 2'h0
`define IBS_KIND_B 2'h1

// field widths in bits
`define IBS_W_KIND 6'h02
`define IBS_W_CHANGE 6'h08
`define IBS_W_RES8 6'h08
`define IBS_W_INTERVAL 6'h16
`define IBS_W_RF_IDX 6'h03
`define IBS_W_START 6'h16
`define IBS_W_BLOCKS 6'h0a
`define IBS_W_NUM_OTHER 6'h08
`define IBS_W_TYPE2 6'h16
`define IBS_W_DELAY 6'h1f
`define IBS_W_ICR 6'h16
`define IBS_W_BUF_SCALE 6'h02
`define IBS_W_BUF_VALUE 6'h0a
`define IBS_W_RATE 6'h1b

// short-form delay used in the ordinary sync field
`define IBS_ISSY_MANT_W 10
`define IBS_ISSY_EXP_W 5

`endif

/* src/ibs_pkg.sv */
/*
  types shared by the in-band padding framer modules.
  assumes ibs_defines.svh is on the include path.
*/
package ibs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HEAD = 3'b001,
        ST_LOOP = 3'b010,
        ST_MID = 3'b011,
        ST_TYPE2 = 3'b100,
        ST_TYPEB = 3'b101,
        ST_DRAIN = 3'b110
    } ibs_state_type;
endpackage

/* src/ibs_field_shifter.sv */
/*
  serialiser that emits one field of up to 32 bits, most significant bit first.
  assumes the loader asks only when accept is high; downstream may stall with bit_ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.svh"
module ibs_field_shifter
    import ibs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [31:0] load_value,
    input wire logic [5:0] load_width,
    output logic accept,
    output logic empty,
    output logic final_bit,
    output logic bit_out,
    output logic bit_valid,
    input wire logic bit_ready
);
    logic [31:0] shreg;
    logic [5:0] remaining;
    wire take = bit_valid & bit_ready;
    wire [5:0] left_shift = 6'h20 - load_width;

    assign bit_valid = remaining != 6'h00;
    assign empty = remaining == 6'h00;
    assign final_bit = remaining == 6'h01;
    // next field may load on the cycle the last bit leaves, so fields abut
    assign accept = empty | (final_bit & bit_ready);
    assign bit_out = shreg[31];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shreg <= 32'h0000_0000;
            remaining <= 6'h00;
        end else if (load) begin
            shreg <= load_value << left_shift;
            remaining <= load_width;
        end else if (take) begin
            shreg <= {shreg[30:0], 1'b0};
            remaining <= remaining - 6'h01;
        end
    end
endmodule
`default_nettype wire

/* src/ibs_delay_encoder.sv */
/*
  converts the plain output-delay count into the short mantissa and exponent form of the sync field.
  assumes delay_count is a same-clock register value.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.svh"
module ibs_delay_encoder
    import ibs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [30:0] delay_count,
    output logic [`IBS_ISSY_MANT_W-1:0] mantissa,
    output logic [`IBS_ISSY_EXP_W-1:0] exponent
);
    // smallest exponent whose shifted count fits; low bits are lost, hence the finer plain field
    function automatic logic [`IBS_ISSY_EXP_W-1:0] find_exp(input logic [30:0] count);
        logic [`IBS_ISSY_EXP_W-1:0] e;
        logic found;
        e = '0;
        found = 1'b0;
        for (int i = 0; i < 31; i++) begin
            if (!found && ((count >> i) < (31'h1 << `IBS_ISSY_MANT_W))) begin
                e = i[`IBS_ISSY_EXP_W-1:0];
                found = 1'b1;
            end
        end
        return e;
    endfunction

    wire [`IBS_ISSY_EXP_W-1:0] next_exponent = find_exp(delay_count);
    wire [30:0] shifted = delay_count >> next_exponent;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mantissa <= '0;
            exponent <= '0;
        end else begin
            mantissa <= shifted[`IBS_ISSY_MANT_W-1:0];
            exponent <= next_exponent;
        end
    end
endmodule
`default_nettype wire

/* test/ibs_framer_sva.sv */
/*
  port checker for the in-band padding framer.
  assumes it is bound to every ibs_framer instance.
*/
`timescale 1ns/1ps
`default_nettype none
module ibs_framer_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bit_out,
    input wire logic bit_valid,
    input wire logic bit_ready,
    input wire logic bit_last,
    input wire logic block_done,
    input wire logic busy,
    input wire logic short_delay_required
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_tail;
        !bit_valid ##1 block_done;
    endsequence
    a_first_kind: assert property (
        $rose(busy) |-> ##1 bit_valid && !bit_out) else $error("block did not open with kind zero");
    a_hold_bit: assert property (
        bit_valid && !bit_ready |=> bit_valid && $stable(bit_out)) else $error("bit changed while stalled");
    a_no_gap: assert property (
        bit_valid && bit_ready && !bit_last |=> bit_valid) else $error("gap inside block");
    a_block_end: assert property (
        bit_valid && bit_ready && bit_last |=> s_tail) else $error("block end out of order");
    a_done_idle: assert property (
        block_done |-> !busy ##1 !block_done) else $error("done pulse or busy wrong");
    a_short_busy: assert property (
        short_delay_required |-> busy) else $error("short delay flag outside block");
    a_err_access: assert property (
        pslverr |-> psel && penable) else $error("error outside access phase");
    a_ready_high: assert property (
        pready) else $error("wait state seen");
    a_valid_busy: assert property (
        bit_valid |-> busy) else $error("bit offered while idle");
endmodule
bind ibs_framer ibs_framer_sva u_sva (.clk, .reset, .psel, .penable, .pready, .pslverr, .bit_out,
    .bit_valid, .bit_ready, .bit_last, .block_done, .busy, .short_delay_required);
`default_nettype wire

/* test/ibs_rx_model.sv */
/*
  receiver model: takes the serial block, may stall one cycle in four.
  assumes the same clock as the framer.
*/
`timescale 1ns/1ps
`default_nettype none
module ibs_rx_model (
    input wire logic clk,
    input wire logic bit_out,
    input wire logic bit_valid,
    input wire logic stall,
    input wire logic clr,
    output logic bit_ready
);
    logic bits [0:511];
    int n = 0;
    logic [1:0] cyc = 2'h0;
    initial bit_ready = 1'b1;
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        // stalls test that offered bits hold
        bit_ready <= !(stall && cyc == 2'h3);
        if (clr) begin
            n <= 0;
        end else if (bit_valid && bit_ready) begin
            bits[n] <= bit_out;
            n <= n + 1;
        end
    end
endmodule
`default_nettype wire

/* test/test_inband_padding_signalling_fields.sv */
/*
  bench for the framer: apb set-up, block runs, bit-exact comparison.
  assumes the receiver model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.svh"
module test_inband_padding_signalling_fields import ibs_pkg::*;
;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic fs = 0, first = 0, stall = 0, clr = 0, err, seen;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, bit_out, bit_valid, bit_ready, bit_last, block_done, busy, sdr;
    logic [9:0] mant;
    logic [4:0] expo;
    logic [21:0] iv [2] = '{22'h000e74, 22'h2aaaa5};
    logic [21:0] sa [2] = '{22'h0, 22'h3c0f0f};
    logic [21:0] t2 [2] = '{22'h0, 22'h155555};
    int n_fail = 0, n_checks = 0;
    logic q [$];
    initial forever #5 clk = ~clk;
    ibs_framer DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .frame_start(fs), .first_of_interleave(first), .bit_out, .bit_valid, .bit_ready,
        .bit_last, .block_done, .busy, .short_delay_required(sdr), .short_delay_mantissa(mant),
        .short_delay_exponent(expo));
    ibs_rx_model rx (.clk, .bit_out, .bit_valid, .stall, .clr, .bit_ready);
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task put(input logic [31:0] v, input int w);
        for (int i = w - 1; i >= 0; i--) q.push_back(v[i]);
    endtask
    task run(input logic f, input int nf, input logic tfs, input logic tb, input logic [31:0] st);
        int k;
        q.delete();
        seen = 0;
        put(0, 2);
        put(8'ha5, 8);
        put(0, 8);
        for (int j = 0; j < nf; j++) begin
            put(iv[j], 22);
            put(tfs ? 6'h15 >> (3 * j) & 6'h7 : 0, 3);
            put(sa[j], 22);
            put(0, 8);
        end
        put(100, 10);
        put(0, 8);
        for (int j = 0; j < nf; j++) put(t2[j], 22);
        if (tb && f) begin
            put(1, 2);
            put(32'h12345, 31);
            put(22'h2abcde, 22);
            put(2, 2);
            put(10'h3a5, 10);
            put(27'h4c4b40, 27);
            put(0, 8);
        end
        clr <= 1;
        first <= f;
        fs <= 1;
        @(posedge clk);
        clr <= 0;
        // second start while busy must be ignored
        @(posedge clk);
        fs <= 0;
        for (k = 0; k < 3000 && block_done !== 1'b1; k++) begin
            @(posedge clk);
            seen |= sdr;
        end
        chk(k < 3000, 1);
        chk(rx.n, q.size());
        chk(rx.n - (36 + 77 * nf), (tb && f) ? 102 : 0);
        for (k = 0; k < q.size(); k++) chk(rx.bits[k], q[k]);
        chk(seen, tb && f);
        apb(0, `IBS_OFF_STATUS, 0);
        chk(rd, st);
    endtask
    task tally_and_finish;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        apb(0, `IBS_OFF_CTRL, 0);
        chk(rd, 32'h6);
        apb(0, 8'h7c, 0);
        chk(rd, 0);
        chk(err, 1);
        // disabled after reset, so this start is dropped
        fs <= 1;
        @(posedge clk);
        fs <= 0;
        repeat (4) @(posedge clk);
        chk(busy, 0);
        $display("test reset and refusal done");
        apb(1, `IBS_OFF_CHANGE, 32'ha5);
        apb(1, `IBS_OFF_BLOCKS, 32'd100);
        apb(1, `IBS_OFF_RF_IDX, 32'h15);
        for (int j = 0; j < 2; j++) begin
            apb(1, `IBS_OFF_INTERVAL + 8'(4 * j), 32'(iv[j]));
            apb(1, `IBS_OFF_START + 8'(4 * j), 32'(sa[j]));
            apb(1, `IBS_OFF_TYPE2 + 8'(4 * j), 32'(t2[j]));
        end
        apb(1, `IBS_OFF_DELAY, 32'h12345);
        apb(1, `IBS_OFF_ICR, 32'h2abcde);
        apb(1, `IBS_OFF_BUF, 32'h3a502);
        apb(1, `IBS_OFF_RATE, 32'h4c4b40);
        apb(1, `IBS_OFF_CTRL, 32'h5);
        run(1, 1, 0, 0, 32'h0001_0000);
        $display("test type a done");
        apb(1, `IBS_OFF_CTRL, 32'h2b);
        stall <= 1;
        run(1, 2, 1, 1, 32'h0002_0006);
        apb(0, `IBS_OFF_ISSY, 0);
        chk(rd, 32'h1e46);
        chk({expo, mant}, 32'h1e46);
        $display("test type b done");
        run(0, 2, 1, 1, 32'h0003_0000);
        $display("test later frame done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
